/* File: nbp_core.sv */
// Purpose: Serial command front end for block erase, reset and block write protection.
// Assumes: SPI mode 0 from the host; all pins are asynchronous to i_sys_clk.
// Notes: The array itself sits outside; an accepted erase leaves as a request pulse.
`timescale 1ns/1ps
// Summary of operation
// [R1] Block erase is ignored unless the write enable latch is set.
// [R2] Host sends the erase opcode right after write enable.
// [R3] Erase address is 24 bits: seven dummy bits, then a 17-bit row.
// [R4] One erase clears exactly the 64-page block holding the registered row.
// [R5] Erase runs internally, busy for the erase busy time, status readable.
// [R6] Reset opcode aborts any operation and returns to idle.
// [R7] Method select bit five of feature B0 picks range or per-block locking.
// [R8] Range mode uses complement, invert and span bits of the range register.
// [R9] Span 0 none, 7 all; otherwise upper fraction, or lower with invert.
// [R10] Complement gives the complementary fraction; with complement set, span six protects block zero only.
// [R11] Per-block lock bits are volatile and all set after power-up or reset.
// [R12] Lock commands take a zero bit, 11-bit block, 12 dummy bits.
// [R13] Individual lock sets the addressed lock bit, busy for lock time.
// [R14] Individual unlock clears the addressed lock bit, busy for lock time.
// [R15] Lock read returns the lock bit as output LSB, one meaning locked.
// [R16] Lock read data shifts out changing on the serial clock falling edge.
// [R17] Erase proceeds on a block whose lock bit is zero.
// [R18] Global lock sets every lock bit after chip select rises, busy.
// [R19] Global unlock clears every lock bit after chip select rises, busy.
// [R20] Erase fail sets on a locked target, clears at erase start or reset.
// [R21] Operation in progress reads one during erase, reset and lock operations.
// [R22] Write enable sets the latch, write disable clears it.
// [R23] With guard set and write protect low, range bits cannot change.
// [R24] The latch clears after an erase completes or is refused; the code clears it at the lock check, before the erase runs.
module nbp_core
  import nbp_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = ERASE_BUSY_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_spi_sck,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  input wire logic i_wp_n,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  output logic o_erase_req,
  output logic [BLK_W-1:0] o_erase_block,
  output logic o_abort,
  output logic o_busy
);
  // Pin synchronisers; only the second and third stages feed logic.
  logic sck_s1, sck_s2, sck_s3;
  logic cs_s1, cs_s2, cs_s3;
  logic mosi_s1, mosi_s2;
  logic wp_s1, wp_s2;

  // Registered state and its next values.
  logic [5:0] bit_cnt, next_bit_cnt;
  logic [23:0] shreg, next_shreg;
  logic [7:0] opcode, next_opcode;
  logic [7:0] feat_addr, next_feat_addr;
  logic [7:0] out_sr, next_out_sr;
  logic [2:0] out_cnt, next_out_cnt;
  logic out_active, next_out_active;
  logic next_miso, next_miso_oe;
  nbp_range_cfg_t cfg, next_cfg;
  logic method_sel, next_method_sel;
  logic write_enable_latch, next_wel;
  logic efail, next_efail;
  nbp_state_t state, next_state;
  logic [31:0] busy_cnt, next_busy_cnt;
  logic chk_wait, next_chk_wait;
  logic [BLK_W-1:0] block, next_block;
  logic [ROW_W-1:0] row, next_row;
  logic next_erase_req, next_abort;
  logic [BLK_W-1:0] next_erase_block;

  // Lock memory controls, computed alongside the next state.
  logic mem_we, mem_wdata, mem_fill, mem_fill_val, lock_bit;
  logic [BLK_W-1:0] mem_waddr;

  logic sck_rise, sck_fall, cs_active, cs_rise, idle;
  logic [5:0] nb;
  logic [23:0] sh_in;

  assign sck_rise = sck_s2 & ~sck_s3;
  assign sck_fall = ~sck_s2 & sck_s3;
  assign cs_active = ~cs_s2;
  assign cs_rise = cs_s2 & ~cs_s3;
  assign idle = (state == ST_IDLE);
  assign nb = bit_cnt + 6'h01;
  assign sh_in = {shreg[22:0], mosi_s2};
  assign o_busy = ~idle; // R21

  nbp_lock_mem u_lock_mem (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_fill(mem_fill),
    .i_fill_val(mem_fill_val),
    .i_raddr(block),
    .o_rdata(lock_bit)
  );

  // Range decode: the protected set is a power-of-two fraction of the rows, or its complement, at either end.
  function automatic logic range_hit(input nbp_range_cfg_t c, input logic [ROW_W-1:0] r);
    logic [17:0] size;
    logic [17:0] rx;
    logic hit;
    size = RANGE_UNIT << c.protect_span_bits;
    rx = {1'b0, r};
    hit = 1'b0;
    if (c.protect_span_bits == SPAN_NONE) begin
      hit = 1'b0; // R9
    end else if (c.protect_span_bits == SPAN_ALL) begin
      hit = 1'b1; // R9
    end else if (c.protect_complement && c.protect_span_bits == SPAN_HALF) begin
      hit = (rx < BLOCK0_ROWS); // R10
    end else begin
      unique case ({c.protect_complement, c.protect_invert})
        2'b00: hit = (rx >= ROW_SPAN - size); // R9
        2'b01: hit = (rx < size); // R9
        2'b10: hit = (rx < ROW_SPAN - size); // R10
        2'b11: hit = (rx >= size); // R10
      endcase
    end
    return hit;
  endfunction : range_hit

  // Byte returned by a feature read; reserved bits read as zero.
  function automatic logic [7:0] feature_byte(input logic [7:0] fa);
    logic [7:0] b;
    b = 8'h00;
    if (fa == FEAT_RANGE) begin
      b = cfg;
    end else if (fa == FEAT_CONFIG) begin
      b[METHOD_BIT] = method_sel;
    end else if (fa == FEAT_STATUS) begin
      b[STAT_OIP_BIT] = ~idle;
      b[STAT_WEL_BIT] = write_enable_latch;
      b[STAT_EFAIL_BIT] = efail;
    end
    return b;
  endfunction : feature_byte

  // Command decode, output shifting and the operation sequencer.
  always_comb begin
    logic [7:0] ob;
    logic load;
    ob = 8'h00;
    load = 1'b0;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_opcode = opcode;
    next_feat_addr = feat_addr;
    next_out_sr = out_sr;
    next_out_cnt = out_cnt;
    next_out_active = out_active;
    next_miso = o_spi_miso;
    next_miso_oe = o_spi_miso_oe;
    next_cfg = cfg;
    next_method_sel = method_sel;
    next_wel = write_enable_latch;
    next_efail = efail;
    next_state = state;
    next_busy_cnt = busy_cnt;
    next_chk_wait = chk_wait;
    next_block = block;
    next_row = row;
    next_erase_req = 1'b0;
    next_erase_block = o_erase_block;
    next_abort = 1'b0;
    mem_we = 1'b0;
    mem_waddr = block;
    mem_wdata = 1'b0;
    mem_fill = 1'b0;
    mem_fill_val = 1'b0;

    // Sequencer: busy countdown, and the lock check one read latency after the address.
    unique case (state)
      ST_IDLE: begin
      end
      ST_CHECK: begin
        next_chk_wait = 1'b1;
        if (chk_wait) begin
          next_chk_wait = 1'b0;
          next_wel = 1'b0; // R24
          if (method_sel ? lock_bit : range_hit(cfg, row)) begin // R7 R8
            next_efail = 1'b1; // R20
            next_state = ST_IDLE;
          end else begin
            next_erase_req = 1'b1; // R17
            next_erase_block = row[ROW_W-1:ERASE_BLK_LSB]; // R4
            next_busy_cnt = 32'(ERASE_CYCLES - 1); // R5
            next_state = ST_BUSY;
          end
        end
      end
      ST_BUSY: begin
        next_busy_cnt = busy_cnt - 32'h0000_0001;
        if (busy_cnt == 32'h0000_0000) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase

    if (!cs_active) begin
      next_bit_cnt = 6'h00;
      next_out_active = 1'b0;
      next_miso_oe = 1'b0;
      next_miso = 1'b0;
      // Global commands act only once the frame closes.
      if (cs_rise && bit_cnt == BITS_OPCODE && idle &&
          (opcode == OPC_GLOBAL_LOCK || opcode == OPC_GLOBAL_UNLOCK)) begin
        mem_fill = 1'b1;
        mem_fill_val = (opcode == OPC_GLOBAL_LOCK); // R18 R19
        next_busy_cnt = 32'(LOCK_BUSY_CYCLES - 1);
        next_state = ST_BUSY;
      end
    end else if (sck_rise) begin
      next_shreg = sh_in;
      if (bit_cnt != BITS_MAX) begin
        next_bit_cnt = nb;
      end
      if (nb == BITS_OPCODE) begin
        next_opcode = sh_in[7:0];
        if (sh_in[7:0] == OPC_RESET) begin
          next_state = ST_BUSY; // R6
          // A reset landing on the check cycle must not also launch the erase.
          next_erase_req = 1'b0; // R6
          next_erase_block = o_erase_block;
          next_busy_cnt = 32'(RESET_BUSY_CYCLES - 1);
          next_chk_wait = 1'b0;
          next_abort = 1'b1; // R6
          next_wel = 1'b0;
          next_efail = 1'b0; // R20
          mem_fill = 1'b1;
          mem_fill_val = 1'b1; // R11
        end else if (idle && sh_in[7:0] == OPC_WRITE_ENABLE) begin
          next_wel = 1'b1; // R22
        end else if (idle && sh_in[7:0] == OPC_WRITE_DISABLE) begin
          next_wel = 1'b0; // R22
        end else if (idle && sh_in[7:0] == OPC_BLOCK_ERASE) begin
          next_efail = 1'b0; // R20
        end
      end else if (nb == BITS_FEAT) begin
        next_feat_addr = sh_in[7:0];
      end else if (nb == BITS_FDATA && idle && opcode == OPC_SET_FEATURE) begin
        if (feat_addr == FEAT_RANGE) begin
          next_cfg.write_guard = sh_in[7];
          if (!(cfg.write_guard && !wp_s2)) begin // R23
            next_cfg = sh_in[7:0];
            next_cfg.reserved = 2'b00;
          end
        end else if (feat_addr == FEAT_CONFIG) begin
          next_method_sel = sh_in[METHOD_BIT]; // R7
        end
      end else if (nb == BITS_ADDR && idle) begin
        if (opcode == OPC_BLOCK_ERASE && write_enable_latch) begin // R1
          next_row = sh_in[ROW_W-1:0]; // R3
          next_block = sh_in[ROW_W-1:ERASE_BLK_LSB];
          next_chk_wait = 1'b0;
          next_state = ST_CHECK; // R5
        end else if (opcode == OPC_BLOCK_LOCK || opcode == OPC_BLOCK_UNLOCK) begin
          mem_we = 1'b1;
          mem_waddr = sh_in[LOCK_BLK_LSB+BLK_W-1:LOCK_BLK_LSB]; // R12
          mem_wdata = (opcode == OPC_BLOCK_LOCK); // R13 R14
          next_busy_cnt = 32'(LOCK_BUSY_CYCLES - 1);
          next_state = ST_BUSY;
        end else if (opcode == OPC_LOCK_READ) begin
          next_block = sh_in[LOCK_BLK_LSB+BLK_W-1:LOCK_BLK_LSB]; // R12
        end
      end
    end else if (sck_fall) begin
      // Output bytes change on the falling edge; a status byte repeats while polled.
      if (opcode == OPC_GET_FEATURE && bit_cnt == BITS_FEAT) begin
        load = 1'b1;
        ob = feature_byte(feat_addr);
      end else if (opcode == OPC_LOCK_READ && bit_cnt == BITS_ADDR) begin
        load = 1'b1;
        ob = {7'h00, lock_bit}; // R15
      end else if (out_active && out_cnt == 3'h7) begin
        load = 1'b1;
        ob = (opcode == OPC_LOCK_READ) ? {7'h00, lock_bit} : feature_byte(feat_addr);
      end
      if (load) begin
        next_miso = ob[7]; // R16
        next_out_sr = {ob[6:0], 1'b0};
        next_out_cnt = 3'h0;
        next_out_active = 1'b1;
        next_miso_oe = 1'b1;
      end else if (out_active) begin
        next_miso = out_sr[7]; // R16
        next_out_sr = {out_sr[6:0], 1'b0};
        next_out_cnt = out_cnt + 3'h1;
      end
    end
  end

  // All state registers; synchronous reset to fixed constants.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
      bit_cnt <= 6'h00;
      shreg <= 24'h00_0000;
      opcode <= 8'h00;
      feat_addr <= 8'h00;
      out_sr <= 8'h00;
      out_cnt <= 3'h0;
      out_active <= 1'b0;
      o_spi_miso <= 1'b0;
      o_spi_miso_oe <= 1'b0;
      cfg <= RANGE_RESET; // R9
      method_sel <= 1'b0;
      write_enable_latch <= 1'b0;
      efail <= 1'b0;
      state <= ST_IDLE;
      busy_cnt <= 32'h0000_0000;
      chk_wait <= 1'b0;
      block <= '0;
      row <= '0;
      o_erase_req <= 1'b0;
      o_erase_block <= '0;
      o_abort <= 1'b0;
    end else begin
      sck_s1 <= i_spi_sck;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      cs_s1 <= i_spi_cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      mosi_s1 <= i_spi_mosi;
      mosi_s2 <= mosi_s1;
      wp_s1 <= i_wp_n;
      wp_s2 <= wp_s1;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      opcode <= next_opcode;
      feat_addr <= next_feat_addr;
      out_sr <= next_out_sr;
      out_cnt <= next_out_cnt;
      out_active <= next_out_active;
      o_spi_miso <= next_miso;
      o_spi_miso_oe <= next_miso_oe;
      cfg <= next_cfg;
      method_sel <= next_method_sel;
      write_enable_latch <= next_wel;
      efail <= next_efail;
      state <= next_state;
      busy_cnt <= next_busy_cnt;
      chk_wait <= next_chk_wait;
      block <= next_block;
      row <= next_row;
      o_erase_req <= next_erase_req;
      o_erase_block <= next_erase_block;
      o_abort <= next_abort;
    end
  end
endmodule : nbp_core

/* File: nbp_pkg.sv */
// Purpose: Shared constants and types of the serial NAND erase, reset and protection block.
// Assumes: 100 MHz system clock; SPI mode 0 framing from the host.
// Notes: Busy times are plain defaults; the erase count is overridable at the top.
package nbp_pkg;
  // Clock and busy times, each figure in its own unit.
  localparam int CLK_PERIOD_NS = 10;
  localparam int ERASE_BUSY_US = 3000;
  localparam int LOCK_BUSY_NS = 20000;
  localparam int RESET_BUSY_NS = 5000;
  localparam int ERASE_BUSY_CYCLES = (ERASE_BUSY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_BUSY_CYCLES = (LOCK_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_BUSY_CYCLES = (RESET_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Command opcodes.
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OPC_RESET = 8'hff;
  localparam logic [7:0] OPC_GET_FEATURE = 8'h0f;
  localparam logic [7:0] OPC_SET_FEATURE = 8'h1f;
  localparam logic [7:0] OPC_BLOCK_LOCK = 8'h36;
  localparam logic [7:0] OPC_BLOCK_UNLOCK = 8'h39;
  localparam logic [7:0] OPC_LOCK_READ = 8'h3d;
  localparam logic [7:0] OPC_GLOBAL_LOCK = 8'h7e;
  localparam logic [7:0] OPC_GLOBAL_UNLOCK = 8'h98;

  // Feature addresses and bit positions.
  localparam logic [7:0] FEAT_RANGE = 8'ha0;
  localparam logic [7:0] FEAT_CONFIG = 8'hb0;
  localparam logic [7:0] FEAT_STATUS = 8'hc0;
  localparam int METHOD_BIT = 5;
  localparam int STAT_OIP_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  localparam int STAT_EFAIL_BIT = 2;

  // Serial bit counts at which fields complete.
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_FEAT = 6'h10;
  localparam logic [5:0] BITS_FDATA = 6'h18;
  localparam logic [5:0] BITS_ADDR = 6'h20;
  localparam logic [5:0] BITS_MAX = 6'h28;

  // Array geometry and address field positions.
  localparam int ROW_W = 17;
  localparam int BLK_W = 11;
  localparam int NUM_BLOCKS = 2048;
  localparam int ERASE_BLK_LSB = 6;
  localparam int LOCK_BLK_LSB = 12;

  // Range protection decode.
  localparam logic [17:0] RANGE_UNIT = 18'h0_0400;
  localparam logic [17:0] ROW_SPAN = 18'h2_0000;
  localparam logic [17:0] BLOCK0_ROWS = 18'h0_0040;
  localparam logic [2:0] SPAN_NONE = 3'h0;
  localparam logic [2:0] SPAN_HALF = 3'h6;
  localparam logic [2:0] SPAN_ALL = 3'h7;

  typedef struct packed {
    logic write_guard;
    logic protect_complement;
    logic protect_invert;
    logic [2:0] protect_span_bits;
    logic [1:0] reserved;
  } nbp_range_cfg_t;

  localparam nbp_range_cfg_t RANGE_RESET = 8'h1c;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_BUSY = 2'b10
  } nbp_state_t;

  typedef enum logic [1:0] {
    OP_ERASE = 2'b00,
    OP_LOCK = 2'b01,
    OP_RESET = 2'b10
  } nbp_op_t;
endpackage : nbp_pkg

/* File: nbp_lock_mem.sv */
// Purpose: Volatile per-block lock bits with one write port, a fill port and registered read.
// Assumes: Fill and write are never requested in the same cycle; fill wins if they are.
// Notes: Every bit comes out of reset set, so the whole array starts locked.
`timescale 1ns/1ps
module nbp_lock_mem
  import nbp_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_we,
  input wire logic [BLK_W-1:0] i_waddr,
  input wire logic i_wdata,
  input wire logic i_fill,
  input wire logic i_fill_val,
  input wire logic [BLK_W-1:0] i_raddr,
  output logic o_rdata
);
  logic [NUM_BLOCKS-1:0] bits;
  logic [NUM_BLOCKS-1:0] next_bits;

  // A global fill touches every bit at once, so a global command updates the whole array in one cycle.
  always_comb begin
    next_bits = bits;
    if (i_fill) begin
      next_bits = {NUM_BLOCKS{i_fill_val}};
    end else if (i_we) begin
      next_bits[i_waddr] = i_wdata;
    end
  end

  // Read data is registered, so it lags the read address by one clock.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      bits <= {NUM_BLOCKS{1'b1}};
      o_rdata <= 1'b1;
    end else begin
      bits <= next_bits;
      o_rdata <= bits[i_raddr];
    end
  end
endmodule : nbp_lock_mem

/* File: nbp_host_model.sv */
// Purpose: Host SPI controller model that issues mode 0 command frames.
// Assumes: Pins move on the falling system clock edge, 80 ns per half bit.
// Notes: Outside frames mosi toggles, so a stale bit is never mistaken for data.
`timescale 1ns/1ps
module nbp_host_model (
  input wire logic i_sys_clk,
  input wire logic i_miso,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_mosi
);
  // The serial clock stands low between frames.
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end

  // Idle pattern on the data line while deselected.
  always @(negedge i_sys_clk) begin
    if (o_cs_n) begin
      o_mosi <= ~o_mosi;
    end
  end

  // Shifts n bits of d MSB first; rx keeps the last eight bits seen at rising edges.
  task automatic frame(input logic [39:0] d, input int n, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge i_sys_clk);
    o_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (8) @(negedge i_sys_clk);
      o_sck = 1'b0;
      o_mosi = d[i];
      repeat (8) @(negedge i_sys_clk);
      o_sck = 1'b1;
      rx = {rx[6:0], i_miso};
    end
    repeat (8) @(negedge i_sys_clk);
    o_sck = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    o_cs_n = 1'b1;
    repeat (8) @(negedge i_sys_clk);
  endtask : frame
endmodule : nbp_host_model

/* File: nbp_core_sva.sv */
// Purpose: Port-level properties of the erase, reset and protection front end.
// Assumes: Bound to nbp_core; the erase count is handed on by the bind.
// Notes: Serial pins are asynchronous, so serial relations allow for sync delay.
`timescale 1ns/1ps
module nbp_core_chk
  import nbp_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = ERASE_BUSY_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_spi_sck,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  input wire logic i_wp_n,
  input wire logic o_spi_miso,
  input wire logic o_spi_miso_oe,
  input wire logic o_erase_req,
  input wire logic [BLK_W-1:0] o_erase_block,
  input wire logic o_abort,
  input wire logic o_busy
);
  localparam int BUSY_LIMIT = ((ERASE_CYCLES > LOCK_BUSY_CYCLES) ?
    ERASE_CYCLES : LOCK_BUSY_CYCLES) + 16;
  logic [19:0] busy_cnt;
  logic [19:0] next_busy_cnt;

  // Busy run length; a busy that never drops would hide every later command.
  always_comb begin
    next_busy_cnt = o_busy ? busy_cnt + 20'h0_0001 : 20'h0_0000;
  end
  always_ff @(posedge i_sys_clk) begin
    busy_cnt <= i_sys_rst ? 20'h0_0000 : next_busy_cnt;
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_busy_run;
    o_busy [*4];
  endsequence
  property p_erase_busy;
    o_erase_req |-> $past(o_busy) ##1 s_busy_run;
  endproperty
  property p_req_pulse;
    o_erase_req |=> !o_erase_req;
  endproperty
  property p_block_hold;
    $changed(o_erase_block) |-> o_erase_req;
  endproperty
  property p_abort_busy;
    o_abort |=> (o_busy && !o_erase_req) [*8];
  endproperty
  property p_abort_pulse;
    o_abort |=> !o_abort;
  endproperty
  property p_miso_fall;
    $changed(o_spi_miso) |-> !i_spi_sck && !$past(i_spi_sck);
  endproperty
  property p_oe_cs;
    i_spi_cs_n [*6] |-> !o_spi_miso_oe;
  endproperty
  property p_busy_bound;
    busy_cnt <= BUSY_LIMIT;
  endproperty

  a_erase_busy: assert property (p_erase_busy)
    else $error("erase request without a following busy period");
  a_req_pulse: assert property (p_req_pulse)
    else $error("erase request longer than one cycle");
  a_block_hold: assert property (p_block_hold)
    else $error("erase block moved without a request");
  a_abort_busy: assert property (p_abort_busy)
    else $error("abort not followed by busy without erase");
  a_abort_pulse: assert property (p_abort_pulse)
    else $error("abort longer than one cycle");
  a_miso_fall: assert property (p_miso_fall)
    else $error("serial output changed while serial clock high");
  a_oe_cs: assert property (p_oe_cs)
    else $error("output enable while deselected");
  a_busy_bound: assert property (p_busy_bound)
    else $error("busy lasted too long");
endmodule : nbp_core_chk

bind nbp_core nbp_core_chk #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_spi_sck(i_spi_sck),
  .i_spi_cs_n(i_spi_cs_n), .i_spi_mosi(i_spi_mosi), .i_wp_n(i_wp_n),
  .o_spi_miso(o_spi_miso), .o_spi_miso_oe(o_spi_miso_oe), .o_erase_req(o_erase_req),
  .o_erase_block(o_erase_block), .o_abort(o_abort), .o_busy(o_busy)
);

/* File: tb_top.sv */
// Purpose: Self-checking bench for erase, reset and block protection commands.
// Assumes: Host model frames at 160 ns per bit; erase count shortened to 400.
// Notes: Erase and lock outcomes are judged by status reads and request pulses.
`timescale 1ns/1ps
module tb_top
  import nbp_pkg::*;
();
  localparam int ERASE_N = 400;
  // Range config, erase row and expected protection.
  localparam logic [25:0] TBL [15] = '{
    {8'h00, 17'h1ffc0, 1'b0}, {8'h04, 17'h1f800, 1'b1}, {8'h04, 17'h1f7c0, 1'b0},
    {8'h24, 17'h007c0, 1'b1}, {8'h24, 17'h00800, 1'b0}, {8'h44, 17'h1f7c0, 1'b1},
    {8'h44, 17'h1f800, 1'b0}, {8'h64, 17'h00800, 1'b1}, {8'h64, 17'h007c0, 1'b0},
    {8'h58, 17'h00000, 1'b1}, {8'h58, 17'h00040, 1'b0}, {8'h18, 17'h10000, 1'b1},
    {8'h18, 17'h0ffc0, 1'b0}, {8'h7c, 17'h00000, 1'b1}, {8'h38, 17'h0ffc0, 1'b1}};
  logic i_sys_clk, i_sys_rst, sck, cs_n, mosi, wp_n, miso, erase_req, abort_p, busy;
  logic miso_oe, oe_q;
  logic [BLK_W-1:0] erase_block;
  logic [7:0] rx;
  int n_fail = 0, n_checks = 0, n_req = 0, n_abort = 0, n_oe = 0;

  nbp_core #(.ERASE_CYCLES(ERASE_N)) dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_spi_sck(sck), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .i_wp_n(wp_n),
    .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .o_erase_req(erase_req),
    .o_erase_block(erase_block), .o_abort(abort_p), .o_busy(busy));
  nbp_host_model host (.i_sys_clk(i_sys_clk), .i_miso(miso), .o_sck(sck),
    .o_cs_n(cs_n), .o_mosi(mosi));

  // Free-running system clock.
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // Pulse counters, so a missed or doubled pulse shows in the totals.
  always @(posedge i_sys_clk) begin
    if (erase_req === 1'b1) n_req++;
    if (abort_p === 1'b1) n_abort++;
    // Output enable must rise once per read frame and drop between frames.
    if (miso_oe === 1'b1 && oe_q !== 1'b1) n_oe++;
    oe_q <= miso_oe;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk11(input logic [BLK_W-1:0] got, input logic [BLK_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk11

  task automatic cmd(input logic [39:0] d, input int n);
    host.frame(d, n, rx);
  endtask : cmd

  task automatic rd(input logic [7:0] fa, input logic [7:0] exp);
    host.frame({OPC_GET_FEATURE, fa, 8'h00}, 24, rx);
    chk8(rx, exp);
  endtask : rd

  task automatic wr(input logic [7:0] fa, input logic [7:0] v);
    host.frame({OPC_SET_FEATURE, fa, v}, 24, rx);
  endtask : wr

  task automatic lrd(input logic [BLK_W-1:0] blk, input logic exp);
    host.frame({OPC_LOCK_READ, 1'b0, blk, 12'hfff, 8'h00}, 40, rx);
    chk8(rx, {7'h00, exp});
  endtask : lrd

  // Bounded wait for the operation to finish.
  task automatic wait_idle();
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 3000) begin
      @(negedge i_sys_clk);
      i++;
    end
    chk8(8'(busy), 8'h00);
  endtask : wait_idle

  task automatic erase(input logic [16:0] row, input logic prot);
    int r0;
    r0 = n_req;
    cmd(OPC_WRITE_ENABLE, 8);
    cmd({OPC_BLOCK_ERASE, 7'h7f, row}, 32);
    wait_idle();
    chk8(8'(n_req - r0), {7'h00, ~prot});
    if (!prot) chk11(erase_block, row[16:6]);
    rd(FEAT_STATUS, {5'h00, prot, 2'b00});
  endtask : erase

  task automatic t_defaults();
    rd(FEAT_STATUS, 8'h00);
    rd(FEAT_RANGE, 8'h1c);
    rd(FEAT_CONFIG, 8'h00);
    chk8(8'(n_oe), 8'h03);
  endtask : t_defaults

  task automatic t_wel();
    cmd({OPC_BLOCK_ERASE, 24'h000040}, 32);
    wait_idle();
    chk8(8'(n_req), 8'h00);
    cmd(OPC_WRITE_ENABLE, 8);
    rd(FEAT_STATUS, 8'h02);
    cmd(OPC_WRITE_DISABLE, 8);
    rd(FEAT_STATUS, 8'h00);
    erase(17'h00040, 1'b1);
  endtask : t_wel

  task automatic t_range();
    for (int i = 0; i < 15; i++) begin
      wr(FEAT_RANGE, TBL[i][25:18]);
      rd(FEAT_RANGE, TBL[i][25:18]);
      erase(TBL[i][17:1], TBL[i][0]);
    end
  endtask : t_range

  task automatic t_locks();
    wr(FEAT_RANGE, 8'h00);
    wr(FEAT_CONFIG, 8'h20);
    erase(17'h00140, 1'b1);
    cmd(OPC_GLOBAL_UNLOCK, 8);
    rd(FEAT_STATUS, 8'h05);
    wait_idle();
    lrd(11'h005, 1'b0);
    cmd({OPC_BLOCK_LOCK, 1'b0, 11'h005, 12'hfff}, 32);
    rd(FEAT_STATUS, 8'h05);
    wait_idle();
    lrd(11'h005, 1'b1);
    lrd(11'h006, 1'b0);
    erase(17'h0017f, 1'b1);
    cmd({OPC_BLOCK_UNLOCK, 1'b0, 11'h005, 12'hfff}, 32);
    wait_idle();
    lrd(11'h005, 1'b0);
    erase(17'h00140, 1'b0);
    cmd(OPC_GLOBAL_LOCK, 8);
    wait_idle();
    lrd(11'h7ff, 1'b1);
  endtask : t_locks

  task automatic t_reset();
    cmd(OPC_GLOBAL_UNLOCK, 8);
    wait_idle();
    wr(FEAT_CONFIG, 8'h00);
    cmd(OPC_WRITE_ENABLE, 8);
    cmd({OPC_BLOCK_ERASE, 24'h000080}, 32);
    cmd(OPC_RESET, 8);
    chk8(8'(n_abort), 8'h01);
    chk8(8'(busy), 8'h01);
    wait_idle();
    rd(FEAT_STATUS, 8'h00);
    wr(FEAT_CONFIG, 8'h20);
    lrd(11'h005, 1'b1);
  endtask : t_reset

  task automatic t_guard();
    wr(FEAT_RANGE, 8'h80);
    @(negedge i_sys_clk);
    wp_n = 1'b0;
    wr(FEAT_RANGE, 8'h9c);
    rd(FEAT_RANGE, 8'h80);
    @(negedge i_sys_clk);
    wp_n = 1'b1;
    wr(FEAT_RANGE, 8'h1c);
    rd(FEAT_RANGE, 8'h1c);
  endtask : t_guard

  task automatic print_verdict();
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // Main sequence after a two-cycle reset.
  initial begin
    i_sys_rst = 1'b1;
    wp_n = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_sys_rst = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    t_defaults();
    t_wel();
    t_range();
    t_locks();
    t_reset();
    t_guard();
    print_verdict();
  end

  // Watchdog sized well above the expected run of about 60000 cycles.
  initial begin
    repeat (95000) @(posedge i_sys_clk);
    n_fail++;
    print_verdict();
  end
endmodule : tb_top
